// ==== hw/barrier_emergency_sequencer.sv ====
/*
  Emergency-close sequencer for one barrier lane with AXI4-Lite registers.
  Assumes panel levels arrive asynchronously and the normal traffic
  sequencer supplies the signal aspect used outside an emergency.
*/
`timescale 1ns/1ps
`default_nettype none

module barrier_emergency_sequencer #(
  parameter int N_STATIONS = 4,
  parameter int TICK_CYCLES = barrier_pkg::SEC_CYCLES,
  parameter int FLASH_CYCLES = barrier_pkg::HALF_FLASH_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // lane field inputs
  input wire barrier_pkg::lane_in_t lane_in,
  input wire logic [N_STATIONS-1:0] station_button,
  // lane field outputs
  output var barrier_pkg::lane_out_t lane_out,
  output logic [N_STATIONS-1:0] station_lamp,
  output logic irq
);
  import barrier_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  localparam int IN_W = $bits(lane_in_t);
  localparam int FW = $clog2(FLASH_CYCLES + 1);
  localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYCLES - 1);

  // synchronised inputs
  logic [IN_W+N_STATIONS-1:0] sync_q;
  lane_in_t sin;
  logic [N_STATIONS-1:0] btn;

  input_sync #(.WIDTH(IN_W + N_STATIONS)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({lane_in, station_button}),
    .q(sync_q)
  );
  assign sin = lane_in_t'(sync_q[IN_W+N_STATIONS-1:N_STATIONS]);
  assign btn = sync_q[N_STATIONS-1:0];

  // sequencer state
  seq_state_t state_reg, state_next;
  logic [N_STATIONS-1:0] pressed_reg, pressed_next;
  logic [N_STATIONS-1:0] btn_prev_reg;
  logic [N_STATIONS-1:0] press;
  logic [N_EV-1:0] irq_stat_reg, irq_stat_next, w1c;
  lane_out_t out_reg, out_next;
  logic [N_STATIONS-1:0] lamp_reg, lamp_next;
  logic act, clear_req, safety_busy, act_n, fault_ev;
  logic seq_start, seq_done, horn_busy, horn_done;
  logic [SEC_W-1:0] seq_secs;
  logic [FW-1:0] flash_cnt_reg, flash_cnt_next;
  logic flash_reg, flash_next;

  // bus state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [N_EV-1:0] mask_reg, mask_next;
  logic sw_clear_reg, sw_clear_next;

  assign press = btn & ~btn_prev_reg;
  // (R14) key switch or software clear
  assign clear_req = sin.emergency_reset | sw_clear_reg;
  // (R2) either detector holds off
  assign safety_busy = sin.safety_detector_a | sin.safety_detector_b;
  // (R1) presses count only in emergency mode
  assign act = (|press) && sin.mode_emergency && !clear_req &&
               state_reg == ST_IDLE;

  sec_timer #(.TICK_CYCLES(TICK_CYCLES), .SEC_W(SEC_W)) u_seq_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(seq_start),
    .secs(seq_secs),
    .busy(),
    .done(seq_done)
  );

  // (R6) ten second horn
  sec_timer #(.TICK_CYCLES(TICK_CYCLES), .SEC_W(SEC_W)) u_horn_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(act),
    .secs(HORN_S),
    .busy(horn_busy),
    .done(horn_done)
  );

  always_comb begin
    state_next = state_reg;
    pressed_next = pressed_reg;
    seq_start = 1'b0;
    seq_secs = YELLOW_S;
    fault_ev = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (act) begin
          pressed_next = press;
          // (R12) raised barrier latches at once
          if (sin.barrier_up) begin
            state_next = ST_LATCHED;
          // (R10) green goes through yellow
          end else if (sin.sig_green_in) begin
            state_next = ST_YELLOW;
            seq_start = 1'b1;
          end else if (!sin.arm_closed) begin
            state_next = ST_ARM_WAIT;
          end else begin
            state_next = ST_SAFETY;
          end
        end
      end
      ST_YELLOW: begin
        if (seq_done) begin
          state_next = ST_ARM_WAIT;
        end
      end
      // (R11) arm closes once detectors clear
      ST_ARM_WAIT: begin
        if (!safety_busy) begin
          state_next = ST_ARM_MOVE;
          seq_start = 1'b1;
          seq_secs = ARM_S;
        end
      end
      // (R8) arm travel time bounds the wait
      ST_ARM_MOVE: begin
        if (seq_done || sin.arm_closed) begin
          state_next = ST_SAFETY;
        end
      end
      // (R3) stop-line detector not consulted
      ST_SAFETY: begin
        if (!safety_busy) begin
          state_next = ST_RAISE;
          seq_start = 1'b1;
          seq_secs = BARRIER_S;
        end
      end
      // (R7) raise, flag late barrier
      ST_RAISE: begin
        if (sin.barrier_up) begin
          state_next = ST_LATCHED;
        end else if (seq_done) begin
          state_next = ST_LATCHED;
          fault_ev = 1'b1;
        end
      end
      ST_LATCHED: begin
        state_next = ST_LATCHED;
      end
    endcase
    // (R14) clear latched command
    if (clear_req && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
      pressed_next = '0;
    end
    // set wins over software clear
    irq_stat_next = irq_stat_reg & ~w1c;
    irq_stat_next[EV_ACT] = irq_stat_next[EV_ACT] | act;
    irq_stat_next[EV_CLEAR] = irq_stat_next[EV_CLEAR] |
                              (clear_req && state_reg != ST_IDLE);
    irq_stat_next[EV_FAULT] = irq_stat_next[EV_FAULT] | fault_ev;
  end

  // outputs follow the next state so they align with state_reg
  always_comb begin
    act_n = (state_next != ST_IDLE);
    // (R9) held raised while latched
    out_next.barrier_raise = (state_next == ST_RAISE) ||
                             (state_next == ST_LATCHED) ||
                             (!sin.mode_emergency && !act_n && sin.close_sw);
    // (R1) panels ignored in emergency mode
    out_next.barrier_lower = !sin.mode_emergency && !act_n &&
                             sin.open_sw && !sin.close_sw;
    // (R13) arm closed before raise
    out_next.arm_close = act_n && state_next != ST_YELLOW &&
                         state_next != ST_ARM_WAIT;
    out_next.sig_yellow = act_n ? state_next == ST_YELLOW :
                          sin.sig_yellow_in;
    out_next.sig_green = !act_n && sin.sig_green_in;
    out_next.sig_red = act_n ? state_next != ST_YELLOW : sin.sig_red_in;
    // (R5) beacons and signs at once
    out_next.beacons = act_n;
    out_next.blankout = act_n;
    out_next.horn = act_n && (act || horn_busy);
    flash_cnt_next = flash_cnt_reg + FW'(1);
    flash_next = flash_reg;
    if (flash_cnt_reg == FLASH_LAST) begin
      flash_cnt_next = '0;
      flash_next = !flash_reg;
    end
  end

  // (R4) steady at all, flash at pressed
  for (genvar i = 0; i < N_STATIONS; i++) begin : g_lamp
    assign lamp_next[i] = act_n && (!pressed_next[i] || flash_reg);
    property p_lamp;
      state_reg != ST_IDLE && !pressed_reg[i] |-> station_lamp[i];
    endproperty
    a_lamp: assert property (p_lamp) // (R4)
      else $error("station lamp dark during emergency");
  end

  // (R15) reset clears timers and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      pressed_reg <= '0;
      btn_prev_reg <= '0;
      irq_stat_reg <= '0;
      out_reg <= '0;
      lamp_reg <= '0;
      flash_cnt_reg <= '0;
      flash_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pressed_reg <= pressed_next;
      btn_prev_reg <= btn;
      irq_stat_reg <= irq_stat_next;
      out_reg <= out_next;
      lamp_reg <= lamp_next;
      flash_cnt_reg <= flash_cnt_next;
      flash_reg <= flash_next;
    end
  end

  assign lane_out = out_reg;
  assign station_lamp = lamp_reg;
  assign irq = |(irq_stat_reg & mask_reg);

  // axi4-lite slave
  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;

  always_comb begin
    aw_hold_next = aw_hold_reg;
    awaddr_next = awaddr_reg;
    w_hold_next = w_hold_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    mask_next = mask_reg;
    sw_clear_next = 1'b0;
    w1c = '0;
    if (awvalid && awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = {awaddr[7:2], 2'h0};
    end
    if (wvalid && wready) begin
      w_hold_next = 1'b1;
      wdata_next = wdata;
      wstrb0_next = wstrb[0];
    end
    if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (awaddr_reg)
        CTRL_OFS: sw_clear_next = wstrb0_reg && wdata_reg[CTRL_CLEAR_BIT];
        STATUS_OFS: bresp_next = RESP_OKAY;
        IRQ_STAT_OFS: w1c = wstrb0_reg ? wdata_reg[N_EV-1:0] : '0;
        IRQ_MASK_OFS: begin
          if (wstrb0_reg) begin
            mask_next = wdata_reg[N_EV-1:0];
          end
        end
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (arvalid && arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      case ({araddr[7:2], 2'h0})
        CTRL_OFS: rdata_next = '0;
        STATUS_OFS: rdata_next = (32'(sin) << STATUS_IN_LSB) |
            (32'(state_reg != ST_IDLE) << STATUS_ACT_BIT) | 32'(state_reg);
        IRQ_STAT_OFS: rdata_next = 32'(irq_stat_reg);
        IRQ_MASK_OFS: rdata_next = 32'(mask_reg);
        default: begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      w_hold_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      mask_reg <= IRQ_MASK_RST;
      sw_clear_reg <= 1'b0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      awaddr_reg <= awaddr_next;
      w_hold_reg <= w_hold_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      mask_reg <= mask_next;
      sw_clear_reg <= sw_clear_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

  // checks

  sequence s_press;
    act;
  endsequence
  sequence s_green_press;
    act && !sin.barrier_up && sin.sig_green_in;
  endsequence

  property p_alert;
    s_press |=> lane_out.beacons && lane_out.blankout && lane_out.horn;
  endproperty
  a_alert: assert property (p_alert) // (R5)
    else $error("beacons, signs or horn not on after press");

  property p_horn_off;
    $fell(lane_out.horn) |-> $past(horn_done) || $past(clear_req);
  endproperty
  a_horn_off: assert property (p_horn_off) // (R6)
    else $error("horn stopped before its time");

  property p_mode_ignore;
    sin.mode_emergency |=> !lane_out.barrier_lower;
  endproperty
  a_mode_ignore: assert property (p_mode_ignore) // (R1)
    else $error("open command passed in emergency mode");

  property p_safety_hold;
    state_reg == ST_SAFETY && safety_busy && sin.mode_emergency
      |=> !lane_out.barrier_raise;
  endproperty
  a_safety_hold: assert property (p_safety_hold) // (R2)
    else $error("barrier raised over a vehicle");

  property p_stopline;
    state_reg == ST_SAFETY && !safety_busy && !clear_req
      |=> state_reg == ST_RAISE && lane_out.barrier_raise;
  endproperty
  a_stopline: assert property (p_stopline) // (R3)
    else $error("raise delayed with safety detectors clear");

  property p_up_now;
    s_press and sin.barrier_up |=> state_reg == ST_LATCHED;
  endproperty
  a_up_now: assert property (p_up_now) // (R12)
    else $error("raised barrier did not latch at once");

  property p_yellow;
    s_green_press |=> lane_out.sig_yellow && !lane_out.sig_green
      ##1 state_reg == ST_YELLOW;
  endproperty
  a_yellow: assert property (p_yellow) // (R10)
    else $error("green not turned to yellow on press");

  property p_latched;
    state_reg == ST_LATCHED && !clear_req
      |=> state_reg == ST_LATCHED && lane_out.barrier_raise &&
          !lane_out.barrier_lower;
  endproperty
  a_latched: assert property (p_latched) // (R9)
    else $error("latched barrier left its raised command");

  property p_clear;
    clear_req && state_reg != ST_IDLE
      |=> state_reg == ST_IDLE && !lane_out.beacons ##1 irq_stat_reg[EV_CLEAR];
  endproperty
  a_clear: assert property (p_clear) // (R14)
    else $error("emergency reset did not clear the latch");

  property p_arm;
    state_reg == ST_ARM_WAIT && !safety_busy && !clear_req
      |=> state_reg == ST_ARM_MOVE && lane_out.arm_close;
  endproperty
  a_arm: assert property (p_arm) // (R11)
    else $error("arm not closing with detectors clear");

  property p_arm_limit;
    state_reg == ST_ARM_MOVE && seq_done && !clear_req
      |=> state_reg == ST_SAFETY;
  endproperty
  a_arm_limit: assert property (p_arm_limit) // (R8)
    else $error("sequence stalled on arm limit switch");

  property p_raise_time;
    state_reg == ST_RAISE && seq_done && !sin.barrier_up && !clear_req
      |=> state_reg == ST_LATCHED ##1 irq_stat_reg[EV_FAULT];
  endproperty
  a_raise_time: assert property (p_raise_time) // (R7)
    else $error("late barrier not flagged");

endmodule // barrier_emergency_sequencer

`default_nettype wire

// ==== inc/barrier_pkg.sv ====
/*
  Shared constants, types and register map of the lane emergency sequencer.
  Assumes a single 10 MHz clock and an AXI4-Lite register bus.
*/
// Operation
// (R1) Emergency mode takes emergency presses, ignores both open/close panels.
// (R2) A raise of a lowered barrier waits until both safety detectors clear.
// (R3) The stop-line detector never affects barrier movement in an emergency.
// (R4) Every station lamp lights steady; the pressed station's lamp flashes.
// (R5) Beacons and blank-out signs switch on at once on a press.
// (R6) The horn sounds for ten seconds after a press, then stops.
// (R7) Lowered barrier with arm closed is raised, fully up within two seconds.
// (R8) Gate arm limit switches never stop or block the emergency sequence.
// (R9) After the close the barrier stays raised, ignoring commands till reset.
// (R10) A green signal shows yellow for two seconds, then turns red.
// (R11) In traffic the arm closes once detectors clear, taking two seconds.
// (R12) An already raised barrier does not wait for the detectors.
// (R13) The raise starts once the arm reports closed, done within two seconds.
// (R14) The emergency reset switch clears the latched emergency command.
// (R15) Seconds come from a clock tick; reset clears timers and outputs.
// (R16) Buttons, key switches and detectors are synchronised before use.

package barrier_pkg;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * TICK_S;
  localparam int FLASH_HALF_MS = 500;
  localparam int HALF_FLASH_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int SEC_W = 4;
  localparam logic [SEC_W-1:0] HORN_S = 4'hA;
  localparam logic [SEC_W-1:0] YELLOW_S = 4'h2;
  localparam logic [SEC_W-1:0] ARM_S = 4'h2;
  localparam logic [SEC_W-1:0] BARRIER_S = 4'h2;

  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int STATUS_ACT_BIT = 4;
  localparam int STATUS_IN_LSB = 8;
  localparam int N_EV = 3;
  localparam int EV_ACT = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_FAULT = 2;
  localparam logic [N_EV-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_YELLOW, ST_ARM_WAIT, ST_ARM_MOVE, ST_SAFETY, ST_RAISE,
    ST_LATCHED
  } seq_state_t;

  typedef struct packed {
    logic mode_emergency;
    logic open_sw;
    logic close_sw;
    logic emergency_reset;
    logic safety_detector_a;
    logic safety_detector_b;
    logic stopline_det;
    logic barrier_up;
    logic barrier_down;
    logic arm_closed;
    logic sig_red_in;
    logic sig_yellow_in;
    logic sig_green_in;
  } lane_in_t;

  typedef struct packed {
    logic barrier_raise;
    logic barrier_lower;
    logic arm_close;
    logic sig_red;
    logic sig_yellow;
    logic sig_green;
    logic beacons;
    logic blankout;
    logic horn;
  } lane_out_t;

endpackage

// ==== hw/input_sync.sv ====
/*
  Two-flop synchroniser for a group of slow panel and detector levels.
  Assumes inputs are static for many clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg, meta_next, sync_reg, sync_next;
    // (R16) two flops per bit
    always_comb begin
      meta_next = d[i];
      sync_next = meta_reg;
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
      end
    end
    assign q[i] = sync_reg;
  end

  property p_sync_delay;
    @(posedge aclk) disable iff (!aresetn)
      $past(aresetn, 2) && $past(aresetn) |-> q == $past(d, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // (R16)
    else $error("synchroniser output is not input delayed by two");

endmodule // input_sync

`default_nettype wire

// ==== hw/sec_timer.sv ====
/*
  Restartable whole-second timer with its own prescaler.
  Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
`default_nettype none

module sec_timer #(
  parameter int TICK_CYCLES = barrier_pkg::SEC_CYCLES,
  parameter int SEC_W = barrier_pkg::SEC_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [SEC_W-1:0] secs,
  output logic busy,
  output logic done
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] PRE_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [SEC_W-1:0] ONE = SEC_W'(1);

  logic [CW-1:0] pre_reg, pre_next;
  logic [SEC_W-1:0] left_reg, left_next;
  logic done_reg, done_next;

  // (R15) seconds from clock tick
  always_comb begin
    pre_next = pre_reg;
    left_next = left_reg;
    done_next = 1'b0;
    if (start) begin
      pre_next = '0;
      left_next = secs;
    end else if (left_reg != '0) begin
      if (pre_reg == PRE_LAST) begin
        pre_next = '0;
        left_next = left_reg - ONE;
        done_next = (left_reg == ONE);
      end else begin
        pre_next = pre_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg <= '0;
      left_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      left_reg <= left_next;
      done_reg <= done_next;
    end
  end

  assign busy = (left_reg != '0);
  assign done = done_reg;

  property p_start_busy;
    @(posedge aclk) disable iff (!aresetn)
      start && secs != '0 |=> busy && !done;
  endproperty
  a_start_busy: assert property (p_start_busy) // (R15)
    else $error("timer not running after start");

endmodule // sec_timer

`default_nettype wire

// ==== testbench/lane_field_model.sv ====
/*
  Field model: barrier and gate arm drives with their limit switches.
  Assumes commands from the sequencer; a full move takes MOVE cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module lane_field_model #(
  parameter int MOVE = 8
) (
  // clock
  input wire logic aclk,
  // drive commands
  input wire barrier_pkg::lane_out_t cmd,
  // limit switches
  output logic up,
  output logic down,
  output logic arm_shut
);
  import barrier_pkg::*;
  int pos = 0;
  int arm = 0;
  always @(posedge aclk) begin
    if (cmd.barrier_raise && pos < MOVE) begin
      pos <= pos + 1;
    end else if (cmd.barrier_lower && pos > 0) begin
      pos <= pos - 1;
    end
    if (cmd.arm_close && arm < MOVE) begin
      arm <= arm + 1;
    end
  end
  assign up = (pos == MOVE);
  assign down = (pos == 0);
  assign arm_shut = (arm == MOVE);
endmodule // lane_field_model

`default_nettype wire

// ==== testbench/barrier_emergency_sequencer_tb_top.sv ====
/*
  Bench for the lane emergency sequencer: AXI4-Lite tasks, field stimulus.
  Assumes a 20-cycle second and a 4-cycle flash half period.
*/
`timescale 1ns/1ps
`default_nettype none

module barrier_emergency_sequencer_tb_top;
  import barrier_pkg::*;
  localparam int RAISE = 8, LOWER = 7, ARM = 6, BEAC = 2, HORN = 0, YEL = 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF, station_button = '0, station_lamp;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, up, down, shut;
  logic [1:0] bresp, rresp, r;
  lane_in_t lin = '0, li;
  lane_out_t lane_out;
  int fails = 0, tests_run = 0, cyc = 0, t0, n;

  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  always_comb begin
    li = lin;
    li.barrier_up = up;
    li.barrier_down = down;
    li.arm_closed = shut;
  end

  barrier_emergency_sequencer #(.TICK_CYCLES(20), .FLASH_CYCLES(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .lane_in(li),
    .station_button(station_button), .lane_out(lane_out),
    .station_lamp(station_lamp), .irq(irq));
  lane_field_model field (.aclk(aclk), .cmd(lane_out), .up(up),
    .down(down), .arm_shut(shut));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic lost(input string nm);
    fails++;
    $display("wrong value %s expected done seen timeout", nm);
    tally_and_finish();
  endtask
  task automatic bus(input logic w, input logic [7:0] a);
    logic ta, tw, tb;
    int k;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    bready <= w;
    rready <= !w;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ta = (awvalid && awready) || (arvalid && arready);
      tw = wvalid && wready;
      tb = w ? bvalid : rvalid;
      r = w ? bresp : rresp;
      if (!w) d = rdata;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (ta) arvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (k == 50) lost("bus");
  endtask
  task automatic wait_out(input int b, input logic v, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (lane_out[b] === v) break;
    end
    if (n == lim) lost("lane output");
  endtask
  task automatic press(input int i);
    @(posedge aclk);
    station_button[i] <= 1'b1;
    t0 = cyc;
    repeat (4) @(posedge aclk);
    station_button[i] <= 1'b0;
    wait_out(BEAC, 1'b1, 8);
  endtask
  task automatic key_clear();
    @(posedge aclk);
    lin.emergency_reset <= 1'b1;
    wait_out(BEAC, 1'b0, 8);
    @(posedge aclk);
    lin.emergency_reset <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("outputs", {lane_out, station_lamp, irq}, 0);
    bus(0, IRQ_MASK_OFS);
    chk("mask", d, 0);
    bus(0, 8'h10);
    chk("unmapped", r, RESP_SLVERR);
    d = 7;
    bus(1, IRQ_MASK_OFS);
    $display("test reset done");
    lin.mode_emergency <= 1'b1;
    lin.sig_green_in <= 1'b1;
    lin.safety_detector_a <= 1'b1;
    lin.stopline_det <= 1'b1;
    lin.open_sw <= 1'b1;
    press(1);
    chk("warn", {lane_out.blankout, lane_out.horn}, 3);
    chk("yellow on", lane_out.sig_yellow, 1);
    chk("lamps", station_lamp | 4'h2, 4'hF);
    wait_out(YEL, 1'b0, 60);
    chk("yellow time", (cyc - t0) inside {[42:48]}, 1);
    chk("red", lane_out.sig_red, 1);
    repeat (6) @(negedge aclk);
    chk("arm held", lane_out.arm_close, 0);
    @(posedge aclk);
    lin.safety_detector_a <= 1'b0;
    wait_out(ARM, 1'b1, 8);
    wait_out(RAISE, 1'b1, 48);
    repeat (12) @(negedge aclk);
    chk("latched", {lane_out.barrier_raise, lane_out.barrier_lower}, 2);
    wait_out(HORN, 1'b0, 250);
    chk("horn time", (cyc - t0) inside {[203:209]}, 1);
    chk("irq", irq, 1);
    d = 1;
    bus(1, IRQ_STAT_OFS);
    chk("irq clear", irq, 0);
    key_clear();
    chk("irq reset", irq, 1);
    bus(0, IRQ_STAT_OFS);
    chk("stat", d, 2);
    $display("test traffic done");
    d = 3;
    bus(1, IRQ_STAT_OFS);
    lin.mode_emergency <= 1'b0;
    wait_out(LOWER, 1'b1, 8);
    repeat (12) @(posedge aclk);
    lin.mode_emergency <= 1'b1;
    lin.open_sw <= 1'b0;
    lin.sig_green_in <= 1'b0;
    lin.safety_detector_b <= 1'b1;
    press(2);
    repeat (10) @(negedge aclk);
    chk("raise held", lane_out.barrier_raise, 0);
    @(posedge aclk);
    lin.safety_detector_b <= 1'b0;
    wait_out(RAISE, 1'b1, 8);
    repeat (10) @(negedge aclk);
    chk("up in time", up, 1);
    d = 1;
    bus(1, CTRL_OFS);
    wait_out(BEAC, 1'b0, 8);
    $display("test lowered done");
    @(posedge aclk);
    lin.safety_detector_a <= 1'b1;
    press(0);
    wait_out(RAISE, 1'b1, 4);
    chk("arm", lane_out.arm_close, 1);
    key_clear();
    $display("test raised done");
    press(3);
    n = 0;
    repeat (8) begin
      @(negedge aclk);
      n += station_lamp[3];
    end
    chk("flash", n, 4);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset outputs", {lane_out, station_lamp, irq}, 0);
    bus(0, IRQ_MASK_OFS);
    chk("reset mask", d, 0);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule // barrier_emergency_sequencer_tb_top

`default_nettype wire
